// [lcs_map.svh]
/*
  Constants of the LED current sink control block: bus address, field positions,
  level codes and timing figures. Assumes a 100 ns reference clock period.
*/
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH

`define LCS_I2C_ADDR 8'h9A
`define LCS_CMD_MSB 7
`define LCS_CMD_LSB 5
`define LCS_LVL_MSB 4
`define LCS_LVL_LSB 0
`define LCS_LEVEL_OFF 5'h00
`define LCS_LEVEL_MIN 5'h01
`define LCS_LEVEL_FULL 5'h1F
`define LCS_PWM_FULL_LEVEL 5'h14
`define LCS_PWM_LINEAR_TOP 5'h08
`define LCS_PWM_SUBRANGE_BASE 5'h09
`define LCS_DUTY_FULL 5'h10
`define LCS_DUTY_SUBRANGE_BASE 5'h0A
`define LCS_PWM_SLOTS 16
`define LCS_POWERUP_CAPTURE 2'h2
`define LCS_POWERUP_DONE 2'h3
`define LCS_T_REF_NS 100
`define LCS_T_OFF_US 4000
`define LCS_T_PULSE_MIN_NS 1000
`define LCS_T_PWM_US 1000

`endif

// [lcs_pkg.sv]
/*
  Types of the LED current sink control block.
  Assumes lcs_map.svh supplies the numeric constants.
*/
`default_nettype none
package lcs_pkg;
  typedef logic [4:0] lcs_level_t;
  typedef logic [2:0] lcs_cmd_t;
  typedef enum logic [5:0] {
    LCS_I2C_IDLE = 6'h01,
    LCS_I2C_ADDR = 6'h02,
    LCS_I2C_ACK_ADDR = 6'h04,
    LCS_I2C_CTRL = 6'h08,
    LCS_I2C_ACK_CTRL = 6'h10,
    LCS_I2C_SKIP = 6'h20
  } lcs_i2c_state_t;
endpackage
`default_nettype wire

// [lcs_bank_if.sv]
/*
  Carrier from one dimming bank timer to the channel logic.
  Assumes a single clock domain on both sides.
*/
`timescale 1ns/1ps
`default_nettype none
interface lcs_bank_if;
  lcs_pkg::lcs_level_t level;
  logic on;
  logic idle;
  modport src (output level, output on, output idle);
  modport dst (input level, input on, input idle);
endinterface
`default_nettype wire

// [lcs_sync.sv]
/*
  Two-flop synchroniser for a vector of levels.
  Assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  if (W < 1) begin : g_w_chk
    $error("synchroniser width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // idle levels of the pins, so no false edge follows reset
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// [lcs_bank_dimmer.sv]
/*
  Pulse dimming timer for one enable pin and its bank of channels.
  Assumes a synchronised enable level on the reference clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.svh"
module lcs_bank_dimmer #(
  parameter int OFF_TIMEOUT_CYC = 40000,
  parameter int PULSE_MIN_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  lcs_bank_if.src bank
);
  localparam int CW = $clog2(OFF_TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] OFF_C = CW'(OFF_TIMEOUT_CYC);
  localparam logic [CW-1:0] MIN_C = CW'(PULSE_MIN_CYC);

  if (PULSE_MIN_CYC < 1 || OFF_TIMEOUT_CYC <= PULSE_MIN_CYC) begin : g_cyc_chk
    $error("off timeout must exceed a nonzero least pulse width");
  end

  logic en_prev_reg;
  logic on_reg;
  logic idle_reg;
  logic [CW-1:0] low_cnt_reg;
  lcs_pkg::lcs_level_t level_reg;
  wire logic [CW-1:0] low_cnt_next;
  wire logic on_next;
  wire lcs_pkg::lcs_level_t level_next;

  wire logic en_rise = i_en & ~en_prev_reg;
  wire logic timed_out = (low_cnt_reg == OFF_C);
  wire logic turn_on = i_en & ~on_reg;
  // glitches below the least pulse width are not counted
  wire logic valid_pulse = en_rise & on_reg & (low_cnt_reg >= MIN_C) & ~timed_out;
  wire logic at_min = (level_reg == `LCS_LEVEL_MIN);

  assign low_cnt_next = i_en ? '0 : (timed_out ? low_cnt_reg : low_cnt_reg + 1'b1);
  assign on_next = turn_on ? 1'b1 : (timed_out ? 1'b0 : on_reg);
  assign level_next = turn_on ? `LCS_LEVEL_FULL :
    (valid_pulse ? (at_min ? `LCS_LEVEL_FULL : level_reg - 5'h01) : level_reg);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_prev_reg <= 1'b0;
      on_reg <= 1'b0;
      idle_reg <= 1'b0;
      low_cnt_reg <= '0;
      level_reg <= `LCS_LEVEL_OFF;
    end else begin
      en_prev_reg <= i_en;
      on_reg <= on_next;
      idle_reg <= timed_out;
      low_cnt_reg <= low_cnt_next;
      level_reg <= level_next;
    end
  end

  assign bank.level = level_reg;
  assign bank.on = on_reg;
  assign bank.idle = idle_reg;
endmodule
`default_nettype wire

// [lcs_top.sv]
/*
  LED current sink control: serial write slave, three-pin pulse dimming,
  low-current PWM gating, regulator enables and charge pump decisions.
  Assumes one 10 MHz reference clock; every pin is asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.svh"

module lcs_top #(
  parameter int OFF_TIMEOUT_CYC = (`LCS_T_OFF_US * 1000 + `LCS_T_REF_NS - 1) / `LCS_T_REF_NS,
  parameter int PWM_PERIOD_CYC = (`LCS_T_PWM_US * 1000) / `LCS_T_REF_NS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_pulse_variant,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_dim_ctrl_first_bank,
  input wire logic i_dim_ctrl_second_bank,
  input wire logic i_dim_ctrl_third_bank,
  input wire logic [5:0] i_sink_channel_dropout,
  input wire logic [5:0] i_sink_channel_tied_to_supply,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [5:0][4:0] o_sink_channel_level,
  output logic [5:0] o_sink_channel_enable,
  output logic [5:0] o_sink_channel_pwm_gate,
  output logic [5:0] o_sink_channel_inverted_rail,
  output logic o_pump_active,
  output logic o_shutdown
);
  localparam int PULSE_MIN_CYC = (`LCS_T_PULSE_MIN_NS + `LCS_T_REF_NS - 1) / `LCS_T_REF_NS;
  localparam int PWM_SLOT_CYC = PWM_PERIOD_CYC / `LCS_PWM_SLOTS;
  localparam int SW = (PWM_SLOT_CYC > 1) ? $clog2(PWM_SLOT_CYC) : 1;
  localparam logic [SW-1:0] SLOT_LAST = SW'(PWM_SLOT_CYC - 1);

  generate
    if (PWM_PERIOD_CYC < `LCS_PWM_SLOTS || (PWM_PERIOD_CYC % `LCS_PWM_SLOTS) != 0) begin : g_pwm_chk
      $error("pwm period must be a nonzero multiple of 16 cycles");
    end
    if (OFF_TIMEOUT_CYC <= PULSE_MIN_CYC) begin : g_off_chk
      $error("off timeout must exceed the least pulse width");
    end
  endgenerate

  // bank of each channel: 0-2 first pin, 3-4 second, 5 third
  function automatic logic [1:0] bank_of(input int ch);
    if (ch < 3) begin
      return 2'h0;
    end else if (ch < 5) begin
      return 2'h1;
    end else begin
      return 2'h2;
    end
  endfunction

  // duty in sixteenths for a level code; full above the PWM range
  function automatic logic [4:0] duty_of(input lcs_pkg::lcs_level_t lvl);
    logic [4:0] rel;
    rel = lvl - `LCS_PWM_SUBRANGE_BASE;
    if (lvl >= `LCS_PWM_FULL_LEVEL) begin
      return `LCS_DUTY_FULL;
    end else if (lvl <= `LCS_PWM_LINEAR_TOP) begin
      return lvl;
    end else begin
      return `LCS_DUTY_SUBRANGE_BASE + {2'h0, rel[1:0], 1'b0};
    end
  endfunction

  // pin synchronisers: scl, sda, three enables, dropout, tied-to-supply
  wire logic [16:0] pins_async = {i_sink_channel_tied_to_supply, i_sink_channel_dropout,
    i_dim_ctrl_third_bank, i_dim_ctrl_second_bank, i_dim_ctrl_first_bank, i_sda, i_scl};
  wire logic [16:0] pins_sync;

  lcs_sync #(
    .W(17),
    .RST_VAL(17'h00003) // scl and sda idle high
  ) u_sync (
    .i_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  wire logic scl_s = pins_sync[0];
  wire logic sda_s = pins_sync[1];
  wire logic [2:0] en_s = pins_sync[4:2];
  wire logic [5:0] dropout_s = pins_sync[10:5];
  wire logic [5:0] tied_s = pins_sync[16:11];

  // serial write slave
  logic scl_d_reg;
  logic sda_d_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic sda_oe_reg;
  logic sda_out_reg;
  lcs_pkg::lcs_i2c_state_t state_reg;
  lcs_pkg::lcs_i2c_state_t state_next;
  lcs_pkg::lcs_level_t i2c_level_reg [6];

  wire logic scl_rise = scl_s & ~scl_d_reg;
  wire logic scl_fall = ~scl_s & scl_d_reg;
  wire logic start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire logic stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire logic byte_done = scl_rise & (bit_cnt_reg == 3'h7);
  wire logic [7:0] rx_byte = {shift_reg[6:0], sda_s};
  wire logic addr_match = (rx_byte == `LCS_I2C_ADDR);
  wire logic in_data = (state_reg == lcs_pkg::LCS_I2C_ADDR) | (state_reg == lcs_pkg::LCS_I2C_CTRL);
  wire logic in_ack = (state_reg == lcs_pkg::LCS_I2C_ACK_ADDR) |
    (state_reg == lcs_pkg::LCS_I2C_ACK_CTRL);
  wire logic cmd_take = byte_done & (state_reg == lcs_pkg::LCS_I2C_CTRL) & ~start_det & ~stop_det;
  wire lcs_pkg::lcs_cmd_t cmd_field = rx_byte[`LCS_CMD_MSB:`LCS_CMD_LSB];
  wire lcs_pkg::lcs_level_t level_field = rx_byte[`LCS_LVL_MSB:`LCS_LVL_LSB];

  // start and stop override any byte state; later bytes are not acknowledged
  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = lcs_pkg::LCS_I2C_ADDR;
    end else if (stop_det) begin
      state_next = lcs_pkg::LCS_I2C_IDLE;
    end else begin
      unique case (state_reg)
        lcs_pkg::LCS_I2C_IDLE: state_next = lcs_pkg::LCS_I2C_IDLE;
        lcs_pkg::LCS_I2C_ADDR: begin
          if (byte_done) begin
            state_next = addr_match ? lcs_pkg::LCS_I2C_ACK_ADDR : lcs_pkg::LCS_I2C_SKIP;
          end
        end
        lcs_pkg::LCS_I2C_ACK_ADDR: begin
          if (scl_rise) begin
            state_next = lcs_pkg::LCS_I2C_CTRL;
          end
        end
        lcs_pkg::LCS_I2C_CTRL: begin
          if (byte_done) begin
            state_next = lcs_pkg::LCS_I2C_ACK_CTRL;
          end
        end
        lcs_pkg::LCS_I2C_ACK_CTRL: begin
          if (scl_rise) begin
            state_next = lcs_pkg::LCS_I2C_SKIP;
          end
        end
        lcs_pkg::LCS_I2C_SKIP: state_next = lcs_pkg::LCS_I2C_SKIP;
        default: state_next = lcs_pkg::LCS_I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= lcs_pkg::LCS_I2C_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      shift_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      shift_reg <= scl_rise ? rx_byte : shift_reg;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_reg <= 3'h0;
    end else if (start_det) begin
      bit_cnt_reg <= 3'h0;
    end else if (scl_rise & in_data) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // acknowledge driven from the fall after bit 8 to the fall after clock 9
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else if (start_det | stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      sda_oe_reg <= in_ack;
    end
  end

  // per-channel levels; codes 0 and 7 select nothing
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_i2c_lvl
      wire logic hit = cmd_take & (cmd_field == 3'(gi + 1));
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          i2c_level_reg[gi] <= `LCS_LEVEL_OFF;
        end else if (hit) begin
          i2c_level_reg[gi] <= level_field;
        end
      end
    end
  endgenerate

  // pulse dimming banks
  lcs_bank_if bank_if [3] ();
  lcs_pkg::lcs_level_t bank_level [3];
  wire logic [2:0] bank_on;
  wire logic [2:0] bank_idle;

  genvar gb;
  generate
    for (gb = 0; gb < 3; gb++) begin : g_bank
      lcs_bank_dimmer #(
        .OFF_TIMEOUT_CYC(OFF_TIMEOUT_CYC),
        .PULSE_MIN_CYC(PULSE_MIN_CYC)
      ) u_dim (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_en(en_s[gb]),
        .bank(bank_if[gb].src)
      );
      assign bank_level[gb] = bank_if[gb].level;
      assign bank_on[gb] = bank_if[gb].on;
      assign bank_idle[gb] = bank_if[gb].idle;
    end
  endgenerate

  // power-up capture of supply-tied channels, once the synchroniser has filled
  logic [1:0] pwr_cnt_reg;
  logic [5:0] tied_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_cnt_reg <= 2'h0;
    end else if (pwr_cnt_reg != `LCS_POWERUP_DONE) begin
      pwr_cnt_reg <= pwr_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tied_reg <= 6'h00;
    end else if (pwr_cnt_reg == `LCS_POWERUP_CAPTURE) begin
      tied_reg <= tied_s;
    end
  end

  // pwm: sixteen slots per period
  logic [SW-1:0] slot_cnt_reg;
  logic [3:0] phase_reg;
  wire logic slot_end = (slot_cnt_reg == SLOT_LAST);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_cnt_reg <= '0;
      phase_reg <= 4'h0;
    end else begin
      slot_cnt_reg <= slot_end ? '0 : slot_cnt_reg + 1'b1;
      phase_reg <= slot_end ? phase_reg + 4'h1 : phase_reg;
    end
  end

  // shutdown: all programmed off in the serial variant, all three pins timed out in the pulse variant
  wire logic [5:0] i2c_nonzero;
  wire logic i2c_all_off = ~|i2c_nonzero;
  wire logic pulse_all_idle = &bank_idle;
  wire logic shutdown_w = i_pulse_variant ? pulse_all_idle : i2c_all_off;

  lcs_pkg::lcs_level_t eff_level [6];
  wire logic [5:0] enable_w;
  wire logic [5:0] gate_w;
  wire logic [5:0] rail_w = enable_w & dropout_s;
  wire logic pump_w = |rail_w;

  genvar gc;
  generate
    for (gc = 0; gc < 6; gc++) begin : g_ch
      localparam logic [1:0] B = bank_of(gc);
      assign i2c_nonzero[gc] = (i2c_level_reg[gc] != `LCS_LEVEL_OFF);
      assign eff_level[gc] = i_pulse_variant ?
        (bank_on[B] ? bank_level[B] : `LCS_LEVEL_OFF) : i2c_level_reg[gc];
      // a shorted channel draws no current once disabled
      assign enable_w[gc] = (eff_level[gc] != `LCS_LEVEL_OFF) & ~shutdown_w &
        ~(i_pulse_variant & tied_reg[gc]);
      // duty never below one slot, since level 1 gives n = 1
      assign gate_w[gc] = enable_w[gc] & (duty_of(eff_level[gc]) > {1'b0, phase_reg});
    end
  endgenerate

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sink_channel_level <= '0;
      o_sink_channel_enable <= 6'h00;
      o_sink_channel_pwm_gate <= 6'h00;
      o_sink_channel_inverted_rail <= 6'h00;
      o_pump_active <= 1'b0;
      o_shutdown <= 1'b0;
    end else begin
      for (int c = 0; c < 6; c++) begin
        o_sink_channel_level[c] <= eff_level[c];
      end
      o_sink_channel_enable <= enable_w;
      o_sink_channel_pwm_gate <= gate_w;
      o_sink_channel_inverted_rail <= rail_w;
      o_pump_active <= pump_w;
      o_shutdown <= shutdown_w;
    end
  end

  assign o_sda_oe = sda_oe_reg;
  assign o_sda_out = sda_out_reg;
endmodule
`default_nettype wire

// [lcs_top_assertions.sv]
/*
  Port checker for lcs_top, bound onto every instance.
  Assumes a serial clock of 8 reference cycles and steady dropout inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_top_assertions #(
  parameter int OFF_TIMEOUT_CYC = 40000,
  parameter int PWM_PERIOD_CYC = 10000
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_pulse_variant,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_dim_ctrl_first_bank,
  input wire logic i_dim_ctrl_second_bank,
  input wire logic i_dim_ctrl_third_bank,
  input wire logic [5:0] i_sink_channel_dropout,
  input wire logic [5:0] i_sink_channel_tied_to_supply,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [5:0][4:0] o_sink_channel_level,
  input wire logic [5:0] o_sink_channel_enable,
  input wire logic [5:0] o_sink_channel_pwm_gate,
  input wire logic [5:0] o_sink_channel_inverted_rail,
  input wire logic o_pump_active,
  input wire logic o_shutdown
);
  logic rdy_reg;
  logic [31:0] hi_cnt_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] all_cnt_reg;
  wire logic [5:0] nz;
  logic all_low;
  assign all_low = !(i_dim_ctrl_first_bank | i_dim_ctrl_second_bank | i_dim_ctrl_third_bank);
  for (genvar c = 0; c < 6; c++) begin : g_nz
    assign nz[c] = |o_sink_channel_level[c];
  end
  // counters stay 32 bit: pins may idle low for the whole run
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdy_reg <= 1'b0;
      hi_cnt_reg <= '0;
      low_cnt_reg <= '0;
      all_cnt_reg <= '0;
    end else begin
      rdy_reg <= 1'b1;
      hi_cnt_reg <= o_sink_channel_pwm_gate[0] ? hi_cnt_reg + 32'h1 : 32'h0;
      low_cnt_reg <= i_dim_ctrl_first_bank ? 32'h0 : low_cnt_reg + 32'h1;
      all_cnt_reg <= all_low ? all_cnt_reg + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_ack_edge;
    $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("ack moved while clock high");
  property p_ack_hold;
    $rose(o_sda_oe) |-> o_sda_oe [*6] ##[1:12] !o_sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not one clock long");
  property p_sda_low;
    o_sda_oe |-> o_sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("ack drives high");
  property p_sd_serial;
    rdy_reg && !i_pulse_variant |-> o_shutdown == (nz == 6'h00);
  endproperty
  a_sd_serial: assert property (p_sd_serial) else $error("serial shutdown wrong");
  property p_bank;
    rdy_reg && i_pulse_variant |-> o_sink_channel_level[0] == o_sink_channel_level[1]
      && o_sink_channel_level[1] == o_sink_channel_level[2]
      && o_sink_channel_level[3] == o_sink_channel_level[4];
  endproperty
  a_bank: assert property (p_bank) else $error("bank channels differ");
  property p_en_lvl;
    (o_sink_channel_enable & ~nz) == 6'h00;
  endproperty
  a_en_lvl: assert property (p_en_lvl) else $error("enabled at level zero");
  property p_pump;
    o_pump_active == (|o_sink_channel_inverted_rail);
  endproperty
  a_pump: assert property (p_pump) else $error("pump disagrees with rails");
  property p_rail;
    (o_sink_channel_inverted_rail & ~($past(i_sink_channel_dropout, 3)
      | $past(i_sink_channel_dropout, 4))) == 6'h00;
  endproperty
  a_rail: assert property (p_rail) else $error("rail moved without dropout");
  property p_pwm_min;
    $fell(o_sink_channel_pwm_gate[0]) && o_sink_channel_level[0] == 5'h01
      && $past(o_sink_channel_level[0], 12) == 5'h01 |-> hi_cnt_reg == PWM_PERIOD_CYC / 16;
  endproperty
  a_pwm_min: assert property (p_pwm_min) else $error("least duty wrong");
  property p_off;
    i_pulse_variant && low_cnt_reg > OFF_TIMEOUT_CYC + 8 |-> !o_sink_channel_enable[0];
  endproperty
  a_off: assert property (p_off) else $error("bank not off after timeout");
  property p_shut;
    i_pulse_variant && all_cnt_reg > OFF_TIMEOUT_CYC + 8 |-> o_shutdown;
  endproperty
  a_shut: assert property (p_shut) else $error("no shutdown with all pins low");
  c_ack: cover property ($rose(o_sda_oe));
  c_wake: cover property ($fell(o_shutdown));
  c_rail: cover property ($rose(o_sink_channel_inverted_rail[1]));
endmodule
bind lcs_top lcs_top_assertions #(.OFF_TIMEOUT_CYC(OFF_TIMEOUT_CYC),
  .PWM_PERIOD_CYC(PWM_PERIOD_CYC)) u_lcs_top_assertions (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_pulse_variant(i_pulse_variant), .i_scl(i_scl), .i_sda(i_sda),
  .i_dim_ctrl_first_bank(i_dim_ctrl_first_bank), .i_dim_ctrl_second_bank(i_dim_ctrl_second_bank),
  .i_dim_ctrl_third_bank(i_dim_ctrl_third_bank), .i_sink_channel_dropout(i_sink_channel_dropout),
  .i_sink_channel_tied_to_supply(i_sink_channel_tied_to_supply), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_sink_channel_level(o_sink_channel_level),
  .o_sink_channel_enable(o_sink_channel_enable), .o_sink_channel_pwm_gate(o_sink_channel_pwm_gate),
  .o_sink_channel_inverted_rail(o_sink_channel_inverted_rail), .o_pump_active(o_pump_active),
  .o_shutdown(o_shutdown));
`default_nettype wire

// [lcs_host_model.sv]
/*
  Far side model: serial write master and pulse driver of the three pins.
  Assumes an open-drain data wire with pull-up built by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module lcs_host_model (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low,
  output logic [2:0] o_dim_ctrl
);
  // clock stands high outside frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_dim_ctrl = 3'h0;
  end
  // 800 ns serial clock, data moves mid low phase
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #200 o_sda_low = !b[i];
      #200 o_scl = 1'b1;
      #400 o_scl = 1'b0;
    end
    #200 o_sda_low = 1'b0;
    #200 o_scl = 1'b1;
    #200 ack = !i_sda;
    #200 o_scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] addr, input logic [7:0] ctrl, output logic [1:0] acks);
    #200 o_sda_low = 1'b1;
    #400 o_scl = 1'b0;
    put_byte(addr, acks[1]);
    put_byte(ctrl, acks[0]);
    #200 o_sda_low = 1'b1;
    #200 o_scl = 1'b1;
    #400 o_sda_low = 1'b0;
    #400;
  endtask
  task automatic dim(input int idx, input int low_ns);
    o_dim_ctrl[idx] = 1'b0;
    #(low_ns) o_dim_ctrl[idx] = 1'b1;
    #2000;
  endtask
  task automatic drive(input int idx, input logic v);
    o_dim_ctrl[idx] = v;
    #2000;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
/*
  Self-checking bench for lcs_top: serial variant first, pulse variant after a reset.
  Assumes lcs_host_model as far side; short timeout and PWM period.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int OFF_CYC = 200;
  localparam int PWM_CYC = 160;
  logic i_ref_clk, i_rst, i_pulse_variant, scl, sda_low, sda_line;
  logic [5:0] i_sink_channel_dropout, i_sink_channel_tied_to_supply;
  logic [2:0] dim;
  logic o_sda_out, o_sda_oe, o_pump_active, o_shutdown;
  logic [5:0][4:0] o_sink_channel_level;
  logic [5:0] o_sink_channel_enable, o_sink_channel_pwm_gate, o_sink_channel_inverted_rail;
  logic [1:0] acks;
  logic [31:0] hi_cnt;
  int num_errors, compares;
  // control byte beside the whole level vector it should leave
  logic [37:0] rows [8] = '{{8'h3F, 30'h1F}, {8'h41, 30'h3F}, {8'h74, 30'h503F},
    {8'h88, 30'h4503F}, {8'hB3, 30'h134503F}, {8'hD4, 30'h2934503F},
    {8'h0F, 30'h2934503F}, {8'hE5, 30'h2934503F}};
  logic [15:0] pwm_rows [6] = '{16'h0101, 16'h0808, 16'h090A, 16'h0C10, 16'h130E, 16'h1410};
  assign sda_line = !sda_low && !(o_sda_oe && !o_sda_out);
  lcs_top #(.OFF_TIMEOUT_CYC(OFF_CYC), .PWM_PERIOD_CYC(PWM_CYC)) u_lcs_top (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pulse_variant(i_pulse_variant),
    .i_scl(scl), .i_sda(sda_line), .i_dim_ctrl_first_bank(dim[0]),
    .i_dim_ctrl_second_bank(dim[1]), .i_dim_ctrl_third_bank(dim[2]),
    .i_sink_channel_dropout(i_sink_channel_dropout),
    .i_sink_channel_tied_to_supply(i_sink_channel_tied_to_supply),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_sink_channel_level(o_sink_channel_level),
    .o_sink_channel_enable(o_sink_channel_enable), .o_sink_channel_pwm_gate(o_sink_channel_pwm_gate),
    .o_sink_channel_inverted_rail(o_sink_channel_inverted_rail),
    .o_pump_active(o_pump_active), .o_shutdown(o_shutdown));
  lcs_host_model u_lcs_host_model (.i_sda(sda_line), .o_scl(scl), .o_sda_low(sda_low),
    .o_dim_ctrl(dim));
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  function automatic logic [29:0] banks(input logic [4:0] a, input logic [4:0] b,
    input logic [4:0] c);
    return {c, b, b, a, a, a};
  endfunction
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #5000000;
    num_errors++;
    conclude();
  end
  initial begin
    i_rst = 1'b1;
    i_pulse_variant = 1'b0;
    i_sink_channel_dropout = 6'h00;
    i_sink_channel_tied_to_supply = 6'h20;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(6);
    check(32'(o_sink_channel_level), 32'h0);
    check(32'(o_shutdown), 32'h1);
    for (int r = 0; r < 8; r++) begin
      u_lcs_host_model.send(8'h9A, rows[r][37:30], acks);
      cyc(4);
      check(32'(acks), 32'h3);
      check(32'(o_sink_channel_level), 32'(rows[r][29:0]));
    end
    check(32'(o_sink_channel_enable), 32'h3F);
    check(32'(o_shutdown), 32'h0);
    u_lcs_host_model.send(8'h9B, 8'h3A, acks);
    cyc(4);
    check(32'(acks), 32'h0);
    check(32'(o_sink_channel_level), 32'h2934503F);
    foreach (pwm_rows[p]) begin
      u_lcs_host_model.send(8'h9A, {3'h1, pwm_rows[p][12:8]}, acks);
      cyc(PWM_CYC);
      hi_cnt = 32'h0;
      repeat (PWM_CYC) begin
        @(negedge i_ref_clk);
        hi_cnt = hi_cnt + 32'(o_sink_channel_pwm_gate[0]);
      end
      check(hi_cnt, 32'(pwm_rows[p][7:0]) * (PWM_CYC / 16));
    end
    @(posedge i_ref_clk);
    i_sink_channel_dropout <= 6'h12;
    cyc(8);
    check(32'(o_sink_channel_inverted_rail), 32'h12);
    check(32'(o_pump_active), 32'h1);
    @(posedge i_ref_clk);
    i_sink_channel_dropout <= 6'h00;
    cyc(8);
    check(32'(o_pump_active), 32'h0);
    for (int c = 1; c <= 6; c++)
      u_lcs_host_model.send(8'h9A, {3'(c), 5'h00}, acks);
    cyc(4);
    check(32'(o_shutdown), 32'h1);
    u_lcs_host_model.send(8'h9A, 8'h7F, acks);
    cyc(4);
    check(32'(o_sink_channel_level), 32'h7C00);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    i_pulse_variant <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(10);
    for (int b = 0; b < 3; b++)
      u_lcs_host_model.drive(b, 1'b1);
    check(32'(o_sink_channel_level), 32'(banks(5'h1F, 5'h1F, 5'h1F)));
    check(32'(o_sink_channel_enable), 32'h1F);
    u_lcs_host_model.dim(0, 2000);
    check(32'(o_sink_channel_level), 32'(banks(5'h1E, 5'h1F, 5'h1F)));
    // below the least pulse width nothing moves
    u_lcs_host_model.dim(0, 500);
    check(32'(o_sink_channel_level), 32'(banks(5'h1E, 5'h1F, 5'h1F)));
    repeat (29) u_lcs_host_model.dim(0, 1500);
    check(32'(o_sink_channel_level), 32'(banks(5'h01, 5'h1F, 5'h1F)));
    u_lcs_host_model.dim(0, 1500);
    check(32'(o_sink_channel_level), 32'(banks(5'h1F, 5'h1F, 5'h1F)));
    u_lcs_host_model.drive(1, 1'b0);
    cyc(OFF_CYC + 50);
    check(32'(o_sink_channel_enable), 32'h07);
    check(32'(o_sink_channel_level), 32'(banks(5'h1F, 5'h00, 5'h1F)));
    check(32'(o_shutdown), 32'h0);
    u_lcs_host_model.drive(0, 1'b0);
    u_lcs_host_model.drive(2, 1'b0);
    cyc(OFF_CYC + 50);
    check(32'(o_shutdown), 32'h1);
    u_lcs_host_model.drive(1, 1'b1);
    check(32'(o_sink_channel_enable), 32'h18);
    conclude();
  end
endmodule
`default_nettype wire
